// *** hw/gpio_bank_pkg.sv ***
// constants for the third/fourth pin bank and sleep indicator block
package gpio_bank_pkg;
  // clock and timing
  localparam int unsigned PCLK_HZ = 40_000_000;
  localparam int unsigned DEBOUNCE_MS = 4;
  localparam int unsigned DEBOUNCE_CYC = PCLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned REF_HZ = 32768;
  localparam int unsigned LED_1HZ_HZ = 1;
  localparam int unsigned LED_QHZ_DIV = 4;
  // reference ticks per half period of each blink rate
  localparam int unsigned LED_1HZ_HALF = REF_HZ / (2 * LED_1HZ_HZ);
  localparam int unsigned LED_QHZ_HALF = REF_HZ * LED_QHZ_DIV / 2;
  // register indices, byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] IDX_B3_STATUS = 8'he7;
  localparam logic [7:0] IDX_B3_DIR = 8'hf0;
  localparam logic [7:0] IDX_B3_DATA = 8'hf1;
  localparam logic [7:0] IDX_B3_INV = 8'hf2;
  localparam logic [7:0] IDX_LED_MODE = 8'hf3;
  localparam logic [7:0] IDX_B4_DIR = 8'hf4;
  localparam logic [7:0] IDX_B4_DATA = 8'hf5;
  localparam logic [7:0] IDX_B4_INV = 8'hf6;
  localparam logic [7:0] IDX_B4_FSEL = 8'hf7;
  localparam logic [7:0] IDX_B3_DTYPE = 8'hfe;
  // reset values
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [1:0] LED_MODE_RST = 2'h0;
  // field layouts
  localparam int unsigned LED_MODE_LSB = 6;
  localparam logic [7:0] DTYPE_MASK = 8'h77;
  localparam int unsigned DT_DEB_LSB = 4;
  localparam int unsigned DT_TRIG_LSB = 0;
  localparam int unsigned FILT_N = 3;
  // sleep indicator modes
  localparam logic [1:0] LED_TRI = 2'h0;
  localparam logic [1:0] LED_LOW = 2'h1;
  localparam logic [1:0] LED_BLINK_1HZ = 2'h2;
  localparam logic [1:0] LED_BLINK_QHZ = 2'h3;

  // detect-type slot k (0..2) maps to third-bank pins 0, 1 and 5
  function automatic int unsigned filt_pin(input int unsigned k);
    filt_pin = (k == 2) ? 5 : k;
  endfunction

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'h0, idx, 2'h0};
  endfunction
endpackage

// *** hw/pin_debounce.sv ***
// debounce filter for one synchronised input pin
`timescale 1ns/10ps
module pin_debounce #(
  parameter int unsigned CYC = gpio_bank_pkg::DEBOUNCE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw,
  output logic clean
);
  localparam int unsigned CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic clean_r;
  logic clean_nxt;

  // output follows only after input held for CYC cycles
  always_comb
  begin
    cnt_nxt = '0;
    clean_nxt = clean_r;
    if (raw != clean_r)
    begin
      if (cnt_r == CW'(CYC - 1))
        clean_nxt = raw;
      else
        cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= '0;
      clean_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      clean_r <= clean_nxt;
    end
  end

  assign clean = clean_r;

  AST_DEB_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(clean_r) |-> $past(cnt_r) == CW'(CYC - 1))
    else $error("debounced output changed before the hold time");
endmodule

// *** hw/gpio_bank_suspend_led.sv ***
// third and fourth pin banks, sleep indicator and apb register slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
// Function
// - direction bit 0 drives the pin, 1 makes it an input; resets to inputs
// - output pins: data bit written and read back; data resets to zero
// - input pins: data bit reflects the pin, writes to it are dropped
// - inversion bit 1 complements data against pin, both directions
// - led mode 00 floats the led, 01 drives it low
// - led mode 10 blinks at one hertz, half period high
// - led mode 11 blinks at a quarter hertz, half period high
// - led mode survives main reset, cleared only by battery reset
// - fourth bank select: odd bits route led, even bits watchdog
// - detect-type bits 6..4 enable debounce on pins 5, 1, 0 when 0
// - detect-type bits 2..0 pick edge (0) or level (1) for 5, 1, 0
// - third bank status bit per pin sets on event, clears on read
module gpio_bank_suspend_led #(
  parameter int unsigned DEBOUNCE_CYC = gpio_bank_pkg::DEBOUNCE_CYC,
  parameter int unsigned LED_1HZ_HALF = gpio_bank_pkg::LED_1HZ_HALF,
  parameter int unsigned LED_QHZ_HALF = gpio_bank_pkg::LED_QHZ_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic vbat_rst_n,
  input wire logic [gpio_bank_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] bank_three_all_pins_in,
  output logic [7:0] bank_three_all_pins_out,
  output logic [7:0] bank_three_all_pins_oe,
  input wire logic [7:0] pin_bank_four_in,
  output logic [7:0] pin_bank_four_out,
  output logic [7:0] pin_bank_four_oe,
  input wire logic ref_clk_in,
  input wire logic watchdog_expiry_out_n,
  output logic sleep_indicator_led_out,
  output logic sleep_indicator_led_oe
);
  localparam int unsigned CW = $clog2(LED_QHZ_HALF + 1);
  localparam int unsigned FILT_N_W = gpio_bank_pkg::FILT_N;

  logic [7:0] b3_s1_r, b3_s2_r, b4_s1_r, b4_s2_r;
  logic ref_s1_r, ref_s2_r, ref_s3_r;
  logic [7:0] b3_dir_r, b3_dat_r, b3_inv_r, b4_dir_r, b4_dat_r;
  logic [7:0] b4_inv_r, b4_fsel_r, dtype_r, sts_r, b3_prev_r;
  logic [7:0] b3_dir_nxt, b3_dat_nxt, b3_inv_nxt, b4_dir_nxt, b4_dat_nxt;
  logic [7:0] b4_inv_nxt, b4_fsel_nxt, dtype_nxt, sts_nxt;
  logic [1:0] led_mode_r, led_mode_nxt;
  logic [CW-1:0] led_cnt_r, led_cnt_nxt;
  logic led_lvl_r, led_lvl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [FILT_N_W-1:0] deb_out;
  logic [7:0] b3_filt, b3_view, b4_view, b3_evt;
  logic wr_en, rd_clr, ref_tick;
  logic [CW-1:0] led_half;

  function automatic logic hit(input logic [gpio_bank_pkg::ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == gpio_bank_pkg::reg_addr(idx));
  endfunction

  // pin and reference inputs cross in through two flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      b3_s1_r <= 8'h00;
      b3_s2_r <= 8'h00;
      b4_s1_r <= 8'h00;
      b4_s2_r <= 8'h00;
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
    end
    else
    begin
      b3_s1_r <= bank_three_all_pins_in;
      b3_s2_r <= b3_s1_r;
      b4_s1_r <= pin_bank_four_in;
      b4_s2_r <= b4_s1_r;
      ref_s1_r <= ref_clk_in;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end

  // debounce filters for the three detect-capable pins
  for (genvar k = 0; k < FILT_N_W; k++)
  begin : g_deb
    pin_debounce #(.CYC(DEBOUNCE_CYC)) u_deb (
      .pclk(pclk),
      .presetn(presetn),
      .raw(b3_s2_r[gpio_bank_pkg::filt_pin(k)]),
      .clean(deb_out[k])
    );
  end

  // filtered pins, data-bit view and event detection
  always_comb
  begin
    b3_filt = b3_s2_r;
    for (int k = 0; k < FILT_N_W; k++)
      if (!dtype_r[gpio_bank_pkg::DT_DEB_LSB + k])
        b3_filt[gpio_bank_pkg::filt_pin(k)] = deb_out[k];
    b3_view = b3_filt ^ b3_inv_r;
    b4_view = b4_s2_r ^ b4_inv_r;
    b3_evt = b3_view & ~b3_prev_r;
    for (int k = 0; k < FILT_N_W; k++)
      if (dtype_r[gpio_bank_pkg::DT_TRIG_LSB + k])
        b3_evt[gpio_bank_pkg::filt_pin(k)] =
          b3_view[gpio_bank_pkg::filt_pin(k)];
  end

  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_clr = psel && penable && !pwrite
                  && hit(paddr, gpio_bank_pkg::IDX_B3_STATUS);

  // main-power registers: writes land at the access edge
  always_comb
  begin
    b3_dir_nxt = b3_dir_r;
    b3_dat_nxt = b3_dat_r;
    b3_inv_nxt = b3_inv_r;
    b4_dir_nxt = b4_dir_r;
    b4_dat_nxt = b4_dat_r;
    b4_inv_nxt = b4_inv_r;
    b4_fsel_nxt = b4_fsel_r;
    dtype_nxt = dtype_r;
    if (wr_en)
    begin
      if (hit(paddr, gpio_bank_pkg::IDX_B3_DIR))
        b3_dir_nxt = pwdata[7:0];
      if (hit(paddr, gpio_bank_pkg::IDX_B3_DATA))
        b3_dat_nxt = (b3_dat_r & b3_dir_r) | (pwdata[7:0] & ~b3_dir_r);
      if (hit(paddr, gpio_bank_pkg::IDX_B3_INV))
        b3_inv_nxt = pwdata[7:0];
      if (hit(paddr, gpio_bank_pkg::IDX_B4_DIR))
        b4_dir_nxt = pwdata[7:0];
      if (hit(paddr, gpio_bank_pkg::IDX_B4_DATA))
        b4_dat_nxt = (b4_dat_r & b4_dir_r) | (pwdata[7:0] & ~b4_dir_r);
      if (hit(paddr, gpio_bank_pkg::IDX_B4_INV))
        b4_inv_nxt = pwdata[7:0];
      if (hit(paddr, gpio_bank_pkg::IDX_B4_FSEL))
        b4_fsel_nxt = pwdata[7:0];
      if (hit(paddr, gpio_bank_pkg::IDX_B3_DTYPE))
        dtype_nxt = pwdata[7:0] & gpio_bank_pkg::DTYPE_MASK;
    end
    // set wins over the read-clear of bits just returned
    sts_nxt = b3_evt | (sts_r & ~(rd_clr ? prdata_r[7:0] : 8'h00));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      b3_dir_r <= gpio_bank_pkg::DIR_RST;
      b3_dat_r <= gpio_bank_pkg::ZERO_RST;
      b3_inv_r <= gpio_bank_pkg::ZERO_RST;
      b4_dir_r <= gpio_bank_pkg::DIR_RST;
      b4_dat_r <= gpio_bank_pkg::ZERO_RST;
      b4_inv_r <= gpio_bank_pkg::ZERO_RST;
      b4_fsel_r <= gpio_bank_pkg::ZERO_RST;
      dtype_r <= gpio_bank_pkg::ZERO_RST;
      sts_r <= gpio_bank_pkg::ZERO_RST;
      b3_prev_r <= gpio_bank_pkg::ZERO_RST;
    end
    else
    begin
      b3_dir_r <= b3_dir_nxt;
      b3_dat_r <= b3_dat_nxt;
      b3_inv_r <= b3_inv_nxt;
      b4_dir_r <= b4_dir_nxt;
      b4_dat_r <= b4_dat_nxt;
      b4_inv_r <= b4_inv_nxt;
      b4_fsel_r <= b4_fsel_nxt;
      dtype_r <= dtype_nxt;
      sts_r <= sts_nxt;
      b3_prev_r <= b3_view;
    end
  end

  // led mode sits on the battery reset only, so main reset keeps it
  always_comb
  begin
    led_mode_nxt = led_mode_r;
    if (wr_en && hit(paddr, gpio_bank_pkg::IDX_LED_MODE))
      led_mode_nxt = pwdata[gpio_bank_pkg::LED_MODE_LSB +: 2];
  end

  always_ff @(posedge pclk or negedge vbat_rst_n)
  begin
    if (!vbat_rst_n)
      led_mode_r <= gpio_bank_pkg::LED_MODE_RST;
    else
      led_mode_r <= led_mode_nxt;
  end

  // blink generator counts reference rising edges, not pclk
  assign ref_tick = ref_s2_r && !ref_s3_r;
  assign led_half = (led_mode_r == gpio_bank_pkg::LED_BLINK_1HZ)
                    ? CW'(LED_1HZ_HALF) : CW'(LED_QHZ_HALF);

  always_comb
  begin
    led_cnt_nxt = led_cnt_r;
    led_lvl_nxt = led_lvl_r;
    case (led_mode_r)
      gpio_bank_pkg::LED_BLINK_1HZ, gpio_bank_pkg::LED_BLINK_QHZ:
      begin
        if (ref_tick)
        begin
          if (led_cnt_r >= led_half - CW'(1))
          begin
            led_cnt_nxt = '0;
            led_lvl_nxt = !led_lvl_r;
          end
          else
            led_cnt_nxt = led_cnt_r + CW'(1);
        end
      end
      default:
      begin
        led_cnt_nxt = '0;
        led_lvl_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led_cnt_r <= '0;
      led_lvl_r <= 1'b0;
    end
    else
    begin
      led_cnt_r <= led_cnt_nxt;
      led_lvl_r <= led_lvl_nxt;
    end
  end

  // led pin: tri-state in 00, low in 01, blink otherwise
  assign sleep_indicator_led_oe = (led_mode_r != gpio_bank_pkg::LED_TRI);
  assign sleep_indicator_led_out = led_lvl_r && led_mode_r[1];

  // pin drivers; output pins carry data xor inversion, selected fourth-bank pins the led or watchdog
  always_comb
  begin
    bank_three_all_pins_out = b3_dat_r ^ b3_inv_r;
    bank_three_all_pins_oe = ~b3_dir_r;
    for (int i = 0; i < 8; i++)
    begin
      if (!b4_fsel_r[i])
      begin
        pin_bank_four_out[i] = b4_dat_r[i] ^ b4_inv_r[i];
        pin_bank_four_oe[i] = !b4_dir_r[i];
      end
      else if (i % 2 == 1)
      begin
        pin_bank_four_out[i] = sleep_indicator_led_out;
        pin_bank_four_oe[i] = sleep_indicator_led_oe;
      end
      else
      begin
        pin_bank_four_out[i] = watchdog_expiry_out_n;
        pin_bank_four_oe[i] = 1'b1;
      end
    end
  end

  // read data captured in setup so the access phase needs no wait
  always_comb
  begin
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (psel && !penable)
    begin
      prdata_nxt = 32'h0000_0000;
      pslverr_nxt = 1'b0;
      case (paddr)
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B3_STATUS):
          prdata_nxt[7:0] = sts_r;
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B3_DIR):
          prdata_nxt[7:0] = b3_dir_r;
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B3_DATA):
          prdata_nxt[7:0] = (b3_view & b3_dir_r) | (b3_dat_r & ~b3_dir_r);
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B3_INV):
          prdata_nxt[7:0] = b3_inv_r;
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_LED_MODE):
          prdata_nxt[7:6] = led_mode_r;
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B4_DIR):
          prdata_nxt[7:0] = b4_dir_r;
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B4_DATA):
          prdata_nxt[7:0] = (b4_view & b4_dir_r) | (b4_dat_r & ~b4_dir_r);
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B4_INV):
          prdata_nxt[7:0] = b4_inv_r;
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B4_FSEL):
          prdata_nxt[7:0] = b4_fsel_r;
        gpio_bank_pkg::reg_addr(gpio_bank_pkg::IDX_B3_DTYPE):
          prdata_nxt[7:0] = dtype_r;
        default:
          pslverr_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = psel && penable;
  assign pslverr = psel && penable && pslverr_r;

  AST_B3_OE_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    bank_three_all_pins_oe == ~b3_dir_r)
    else $error("third bank enable does not follow direction");
  AST_OUT_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, gpio_bank_pkg::IDX_B3_DATA) && b3_dir_r == 8'h00
    |=> bank_three_all_pins_out == ($past(pwdata[7:0]) ^ b3_inv_r))
    else $error("written output level not on the pins");
  AST_IN_WRITE_DROP: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && hit(paddr, gpio_bank_pkg::IDX_B4_DATA) && b4_dir_r == 8'hff
    |=> $stable(b4_dat_r))
    else $error("write to input pins changed data");
  AST_LED_MODES: assert property (@(posedge pclk) disable iff (!presetn)
    led_mode_r == gpio_bank_pkg::LED_LOW
    |-> sleep_indicator_led_oe && !sleep_indicator_led_out)
    else $error("led not driven low in low mode");
  AST_LED_1HZ: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(led_lvl_r) && $past(led_mode_r) == gpio_bank_pkg::LED_BLINK_1HZ
    |-> $past(led_cnt_r) == CW'(LED_1HZ_HALF - 1))
    else $error("one hertz half period wrong");
  AST_LED_QHZ: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(led_lvl_r) && $past(led_mode_r) == gpio_bank_pkg::LED_BLINK_QHZ
    |-> $past(led_cnt_r) == CW'(LED_QHZ_HALF - 1))
    else $error("quarter hertz half period wrong");
  AST_VBAT_KEEP: assert property (@(posedge pclk) disable iff (!vbat_rst_n)
    !presetn |=> led_mode_r == $past(led_mode_r))
    else $error("led mode lost on main reset");
  AST_FSEL_WDT: assert property (@(posedge pclk) disable iff (!presetn)
    b4_fsel_r[0] |-> pin_bank_four_oe[0]
    && pin_bank_four_out[0] == watchdog_expiry_out_n)
    else $error("watchdog not routed to fourth bank pin");
  AST_LEVEL_SET: assert property (@(posedge pclk) disable iff (!presetn)
    dtype_r[0] && b3_view[0] |=> sts_r[0])
    else $error("level event did not set status");
  AST_STATUS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    b3_evt[7] |=> sts_r[7])
    else $error("event lost from status");
endmodule

// *** sim/pin_board_model.sv ***
// board model: pin levels on both banks and the slow reference clock
`timescale 1ns/10ps
module pin_board_model #(
  parameter int unsigned REF_HALF_NS = 125
) (
  input wire logic [7:0] b3_out,
  input wire logic [7:0] b3_oe,
  input wire logic [7:0] b3_board,
  input wire logic [7:0] b4_out,
  input wire logic [7:0] b4_oe,
  input wire logic [7:0] b4_board,
  output logic [7:0] b3_wire,
  output logic [7:0] b4_wire,
  output logic ref_clk
);
  // a driven pin shows the block's level, a released one the board's
  assign b3_wire = (b3_oe & b3_out) | (~b3_oe & b3_board);
  assign b4_wire = (b4_oe & b4_out) | (~b4_oe & b4_board);

  // free-running reference, offset so its phase is unrelated to pclk
  initial
  begin
    ref_clk = 1'b0;
    #3;
    forever #(REF_HALF_NS) ref_clk = ~ref_clk;
  end
endmodule

// *** sim/tb_gpio_bank_suspend_led.sv ***
// self-checking bench for the pin banks and the sleep indicator
`timescale 1ns/10ps
module tb_gpio_bank_suspend_led;
  localparam int unsigned REF_CYC = 10; // pclk cycles per reference period
  localparam int unsigned H1 = 2;
  localparam int unsigned HQ = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic vbat_rst_n = 1'b0;
  logic [gpio_bank_pkg::ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] b3_in, b3_out, b3_oe, b4_in, b4_out, b4_oe;
  logic [7:0] b3_board = 8'h00;
  logic [7:0] b4_board = 8'h00;
  logic ref_clk;
  logic wdt_n = 1'b1;
  logic led_out, led_oe;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int total_checks = 0;
  int hi, per;
  logic [7:0] ridx [10] = '{8'he7, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4,
                           8'hf5, 8'hf6, 8'hf7, 8'hfe};
  logic [7:0] rrst [10] = '{8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff,
                           8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] slot_pin [3] = '{8'h01, 8'h02, 8'h20};

  // main clock, 25 ns period
  always #12.5 pclk = ~pclk;

  gpio_bank_suspend_led #(
    .DEBOUNCE_CYC(4),
    .LED_1HZ_HALF(H1),
    .LED_QHZ_HALF(HQ)
  ) gpio_bank_suspend_led_inst (
    .pclk(pclk),
    .presetn(presetn),
    .vbat_rst_n(vbat_rst_n),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bank_three_all_pins_in(b3_in),
    .bank_three_all_pins_out(b3_out),
    .bank_three_all_pins_oe(b3_oe),
    .pin_bank_four_in(b4_in),
    .pin_bank_four_out(b4_out),
    .pin_bank_four_oe(b4_oe),
    .ref_clk_in(ref_clk),
    .watchdog_expiry_out_n(wdt_n),
    .sleep_indicator_led_out(led_out),
    .sleep_indicator_led_oe(led_oe)
  );

  pin_board_model #(
    .REF_HALF_NS(REF_CYC * 25 / 2)
  ) pin_board_model_inst (
    .b3_out(b3_out),
    .b3_oe(b3_oe),
    .b3_board(b3_board),
    .b4_out(b4_out),
    .b4_oe(b4_oe),
    .b4_board(b4_board),
    .b3_wire(b3_in),
    .b4_wire(b4_in),
    .ref_clk(ref_clk)
  );

  // compare one value and count it
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 16)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check($sformatf("reg %h", idx), rd, {24'h00_0000, exp});
  endtask

  // let the edge's updates land before looking at outputs
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // high time and period of the led, in pclk cycles
  task automatic blink(output int h, output int p);
    int n;
    n = 0;
    // polled on the falling edge, where the led level has settled
    while (led_out !== 1'b0 && n < 500)
    begin
      @(negedge pclk);
      n++;
    end
    while (led_out !== 1'b1 && n < 500)
    begin
      @(negedge pclk);
      n++;
    end
    h = 0;
    while (led_out === 1'b1 && h < 500)
    begin
      @(negedge pclk);
      h++;
    end
    p = h;
    while (led_out === 1'b0 && p < 500)
    begin
      @(negedge pclk);
      p++;
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // cut a hang short well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge pclk);
    fails++;
    results();
  end

  // test sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    vbat_rst_n <= 1'b1;
    foreach (ridx[i])
      rdc(ridx[i], rrst[i]);
    apb(1'b0, 8'h10, 8'h00);
    check("unmapped err", {31'h0, err}, 32'h0000_0001);
    check("unmapped data", rd, 32'h0000_0000);
    check("oe3 reset", b3_oe, 8'h00);
    // outputs on the low nibble, writes to input bits are dropped
    b3_board <= 8'hc0;
    wr(gpio_bank_pkg::IDX_B3_DIR, 8'hf0);
    wr(gpio_bank_pkg::IDX_B3_DATA, 8'hff);
    settle(4);
    check("oe3", b3_oe, 8'h0f);
    check("out3", b3_out, 8'h0f);
    rdc(gpio_bank_pkg::IDX_B3_DATA, 8'hcf);
    wr(gpio_bank_pkg::IDX_B3_DIR, 8'h00);
    settle(1);
    check("out3 all", b3_out, 8'h0f);
    wr(gpio_bank_pkg::IDX_B3_DATA, 8'ha5);
    settle(1);
    check("out3 a5", b3_out, 8'ha5);
    wr(gpio_bank_pkg::IDX_B3_DATA, 8'h0f);
    // inversion on outputs and on inputs
    wr(gpio_bank_pkg::IDX_B3_INV, 8'h11);
    settle(1);
    check("out3 inv", b3_out, 8'h1e);
    rdc(gpio_bank_pkg::IDX_B3_DATA, 8'h0f);
    wr(gpio_bank_pkg::IDX_B3_DIR, 8'hff);
    b3_board <= 8'h01;
    settle(6); // two sync flops plus the debounce hold on pin 0
    rdc(gpio_bank_pkg::IDX_B3_DATA, 8'h10);
    // fourth bank and its function select
    wr(gpio_bank_pkg::IDX_B4_DATA, 8'hff);
    wr(gpio_bank_pkg::IDX_B4_DIR, 8'h00);
    settle(1);
    check("out4 drop", b4_out, 8'h00);
    wr(gpio_bank_pkg::IDX_B4_DATA, 8'h5a);
    settle(1);
    check("oe4", b4_oe, 8'hff);
    check("out4", b4_out, 8'h5a);
    wr(gpio_bank_pkg::IDX_LED_MODE, 8'h40);
    wr(gpio_bank_pkg::IDX_B4_FSEL, 8'h03);
    wdt_n <= 1'b0;
    settle(2);
    check("led low", {30'h0, led_oe, led_out}, 32'h0000_0002);
    check("out4 fsel", b4_out, 8'h58);
    @(posedge pclk);
    wdt_n <= 1'b1;
    settle(2);
    check("out4 wdt", b4_out, 8'h59);
    wr(gpio_bank_pkg::IDX_LED_MODE, 8'h00);
    settle(1);
    check("led float", {31'h0, led_oe}, 32'h0000_0000);
    // blink rates, counted in pclk cycles
    wr(gpio_bank_pkg::IDX_LED_MODE, 8'h80);
    blink(hi, per);
    check("fast high", hi, H1 * REF_CYC);
    check("fast period", per, 2 * H1 * REF_CYC);
    wr(gpio_bank_pkg::IDX_LED_MODE, 8'hc0);
    blink(hi, per);
    check("slow high", hi, HQ * REF_CYC);
    check("slow period", per, 2 * HQ * REF_CYC);
    // main reset spares the led mode, battery reset clears it
    wr(gpio_bank_pkg::IDX_LED_MODE, 8'h40);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(gpio_bank_pkg::IDX_LED_MODE, 8'h40);
    rdc(gpio_bank_pkg::IDX_B3_DIR, 8'hff);
    @(posedge pclk);
    vbat_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    vbat_rst_n <= 1'b1;
    rdc(gpio_bank_pkg::IDX_LED_MODE, 8'h00);
    // plain pin edge, then clear on read
    b3_board <= 8'h00;
    settle(12);
    apb(1'b0, gpio_bank_pkg::IDX_B3_STATUS, 8'h00);
    b3_board <= 8'h04;
    settle(6);
    rdc(gpio_bank_pkg::IDX_B3_STATUS, 8'h04);
    rdc(gpio_bank_pkg::IDX_B3_STATUS, 8'h00);
    // debounced pin ignores a short glitch, takes a long hold
    b3_board <= 8'h05;
    repeat (2) @(posedge pclk);
    b3_board <= 8'h04;
    settle(12);
    rdc(gpio_bank_pkg::IDX_B3_STATUS, 8'h00);
    b3_board <= 8'h05;
    settle(12);
    rdc(gpio_bank_pkg::IDX_B3_STATUS, 8'h01);
    // each filtered slot: bypassed glitch, then level trigger
    foreach (slot_pin[k])
    begin
      b3_board <= 8'h00;
      wr(gpio_bank_pkg::IDX_B3_DTYPE, 8'h70);
      settle(12);
      apb(1'b0, gpio_bank_pkg::IDX_B3_STATUS, 8'h00);
      b3_board <= slot_pin[k];
      repeat (2) @(posedge pclk);
      b3_board <= 8'h00;
      settle(6);
      rdc(gpio_bank_pkg::IDX_B3_STATUS, slot_pin[k]);
      wr(gpio_bank_pkg::IDX_B3_DTYPE, 8'h70 | (8'h01 << k));
      b3_board <= slot_pin[k];
      settle(6);
      rdc(gpio_bank_pkg::IDX_B3_STATUS, slot_pin[k]);
      rdc(gpio_bank_pkg::IDX_B3_STATUS, slot_pin[k]);
      b3_board <= 8'h00;
      settle(6);
      rdc(gpio_bank_pkg::IDX_B3_STATUS, slot_pin[k]);
      rdc(gpio_bank_pkg::IDX_B3_STATUS, 8'h00);
    end
    results();
  end
endmodule
